// ---- bench/tb.sv ----
// Self-checking testbench for the thermometer scratchpad logic
`timescale 1ns/100ps
`default_nettype none
module tb;
    import tsa_pkg::*;
    // --------
    // Signals
    // --------
    localparam int RCL = 8;
    localparam logic [15:0] TEMPS [6] = '{16'h0034, 16'h0033, 16'h000a,
                                         16'h000c, 16'hffce, 16'h0232};
    logic        mclk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic        bus_reset_i = 1'b0;
    logic        cmd_valid_i = 1'b0;
    logic [7:0]  cmd_code_i = 8'h00;
    logic        wr_bit_valid_i = 1'b0;
    logic        wr_bit_i = 1'b0;
    logic        rd_slot_i = 1'b0;
    logic        parasite_i = 1'b0;
    logic        conv_done_i;
    tsa_result_t conv_result_i;
    tsa_result_t sensor_value = '0;
    logic        rd_bit_o, rd_valid_o, conv_start_o, alarm_o, busy_o;
    logic [63:0] rom_code_o;
    logic [7:0]  sp [0:8];
    logic [7:0]  th = 8'h19;
    logic [7:0]  tl = 8'h05;
    int          err_count = 0;
    int          comparisons = 0;
    always #2.5 mclk_i = ~mclk_i;
    tsa_scratchpad #(.NV_WRITE_CYC(20), .RECALL_CYC(RCL)) u_dut (
        .mclk_i(mclk_i), .rst_b_i(rst_b_i), .bus_reset_i(bus_reset_i),
        .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i),
        .wr_bit_valid_i(wr_bit_valid_i), .wr_bit_i(wr_bit_i),
        .rd_slot_i(rd_slot_i), .conv_done_i(conv_done_i),
        .conv_result_i(conv_result_i), .parasite_i(parasite_i),
        .rd_bit_o(rd_bit_o), .rd_valid_o(rd_valid_o),
        .conv_start_o(conv_start_o), .alarm_o(alarm_o), .busy_o(busy_o),
        .rom_code_o(rom_code_o));
    tsa_sensor_model #(.LAT(10)) u_sensor (.mclk_i(mclk_i),
        .rst_b_i(rst_b_i), .start_i(conv_start_o), .value_i(sensor_value),
        .done_o(conv_done_i), .result_o(conv_result_i));
    // --------
    // Tasks
    // --------
    function automatic logic [7:0] crc_of(input logic [63:0] d, input int n);
        logic [7:0] c;
        logic       mix;
        c = 8'h00;
        for (int i = 0; i < n * 8; i++) begin
            mix = c[0] ^ d[i];
            c = mix ? ((c >> 1) ^ CRC_POLY_REF) : (c >> 1);
        end
        return c;
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick();
        @(posedge mclk_i);
        #1;
    endtask
    task automatic send_cmd(input logic [7:0] code);
        cmd_code_i = code;
        cmd_valid_i = 1'b1;
        tick();
        cmd_valid_i = 1'b0;
        tick();
    endtask
    task automatic wr_bytes(input logic [23:0] d, input int n);
        wr_bit_valid_i = 1'b1;
        for (int i = 0; i < n * 8; i++) begin
            wr_bit_i = d[i];
            tick();
        end
        wr_bit_valid_i = 1'b0;
        tick();
    endtask
    task automatic rd_bits(input int n, output logic [71:0] q);
        q = '1;
        rd_slot_i = 1'b1;
        for (int i = 0; i < n; i++) begin
            tick();
            chk(rd_valid_o, 1'b1);
            q[i] = rd_bit_o;
        end
        rd_slot_i = 1'b0;
        tick();
    endtask
    task automatic rd_spad();
        logic [71:0] q;
        send_cmd(CMD_READ);
        rd_bits(72, q);
        for (int i = 0; i < 9; i++) begin
            sp[i] = q[i*8 +: 8];
        end
        chk({sp[5], sp[4]}, {RSVD_VALUE, RSVD_VALUE});
        chk(sp[8], crc_of(q[63:0], 8));
        chk({sp[3], sp[2]}, {tl, th});
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy_o !== 1'b0 && n < 400) begin
            tick();
            n++;
        end
        chk(busy_o, 1'b0);
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk_i);
        err_count++;
        end_sim();
    end
    // --------
    // Tests
    // --------
    initial begin
        logic [71:0] q;
        logic [7:0]  c;
        repeat (20) @(posedge mclk_i);
        #1 rst_b_i = 1'b1;
        th = NV_HIGH_INIT;
        tl = NV_LOW_INIT;
        wait_idle();
        chk(alarm_o, 1'b0);
        rd_spad();
        chk({sp[1], sp[0]}, TEMP_RESET);
        c = crc_of({8'h00, SERIAL_NUM, FAMILY_CODE}, 7);
        chk(rom_code_o, {c, SERIAL_NUM, FAMILY_CODE});
        $display("test reset_contents done");
        send_cmd(CMD_READ);
        rd_bits(3, q);
        bus_reset_i = 1'b1;
        tick();
        bus_reset_i = 1'b0;
        send_cmd(CMD_WRITE);
        wr_bytes(24'h33_05_19, 3);
        th = 8'h19;
        tl = 8'h05;
        rd_spad();
        $display("test write_thresholds done");
        foreach (TEMPS[i]) begin
            sensor_value = {TEMPS[i], 8'h0c, 8'h10};
            send_cmd(CMD_CONVERT);
            rd_bits(1, q);
            chk(q[0], 1'b0);
            wait_idle();
            chk(alarm_o, $signed(TEMPS[i][8:1]) <= $signed(tl)
                || $signed(TEMPS[i][8:1]) > $signed(th));
            rd_spad();
            chk({sp[7], sp[6], sp[1], sp[0]}, {16'h100c, TEMPS[i]});
        end
        $display("test alarm_compare done");
        parasite_i = 1'b1;
        send_cmd(CMD_POWER);
        rd_bits(2, q);
        chk(q[1:0], 2'b00);
        parasite_i = 1'b0;
        send_cmd(CMD_POWER);
        rd_bits(1, q);
        chk(q[0], 1'b1);
        $display("test power_mode done");
        send_cmd(CMD_COPY);
        wait_idle();
        send_cmd(CMD_WRITE);
        wr_bytes(24'h00_aa_55, 2);
        send_cmd(CMD_RECALL);
        rd_bits(RCL + 4, q);
        chk({q[RCL+3], q[0]}, 2'b10);
        wait_idle();
        rd_spad();
        $display("test copy_recall done");
        end_sim();
    end
endmodule
`default_nettype wire

// ---- bench/tsa_scratchpad_asserts.sv ----
// Port checker for the thermometer scratchpad logic
`timescale 1ns/100ps
`default_nettype none
module tsa_scratchpad_asserts
    import tsa_pkg::*;
#(
    parameter logic [7:0]  FAMILY = 8'h00,
    parameter logic [47:0] SERIAL = 48'h0
) (
    input  wire logic                 mclk_i,
    input  wire logic                 rst_b_i,
    input  wire logic                 bus_reset_i,
    input  wire logic                 cmd_valid_i,
    input  wire logic [7:0]           cmd_code_i,
    input  wire logic                 wr_bit_valid_i,
    input  wire logic                 wr_bit_i,
    input  wire logic                 rd_slot_i,
    input  wire logic                 conv_done_i,
    input  wire tsa_pkg::tsa_result_t conv_result_i,
    input  wire logic                 parasite_i,
    input  wire logic                 rd_bit_o,
    input  wire logic                 rd_valid_o,
    input  wire logic                 conv_start_o,
    input  wire logic                 alarm_o,
    input  wire logic                 busy_o,
    input  wire logic [63:0]          rom_code_o
);
    // --------
    // Checks
    // --------
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    read_answer_a: assert property (rd_slot_i |=> rd_valid_o)
        else $error("read slot not answered");
    read_pulse_a: assert property (rd_valid_o |-> $past(rd_slot_i))
        else $error("read answer without slot");
    conv_start_a: assert property (cmd_valid_i && !busy_o
        && cmd_code_i == CMD_CONVERT |=> conv_start_o && busy_o)
        else $error("convert command not started");
    conv_cause_a: assert property (conv_start_o |-> $past(cmd_valid_i)
        && $past(cmd_code_i) == CMD_CONVERT)
        else $error("conversion start without command");
    conv_pulse_a: assert property (conv_start_o |=> !conv_start_o)
        else $error("conversion start longer than one cycle");
    alarm_hold_a: assert property (!$past(conv_done_i)
        |-> $stable(alarm_o))
        else $error("alarm changed without conversion");
    busy_answer_a: assert property (rd_slot_i && busy_o && !conv_done_i
        |=> !rd_bit_o)
        else $error("busy device answered one");
    rom_code_a: assert property ($past(rst_b_i)
        |-> rom_code_o[55:0] == {SERIAL, FAMILY})
        else $error("identity code wrong");
    busy_rise_a: assert property ($rose(busy_o) |-> $past(cmd_valid_i))
        else $error("busy without command");
endmodule
bind tsa_scratchpad tsa_scratchpad_asserts #(
    .FAMILY(FAMILY),
    .SERIAL(SERIAL)
) u_chk (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .bus_reset_i(bus_reset_i),
    .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i),
    .wr_bit_valid_i(wr_bit_valid_i), .wr_bit_i(wr_bit_i),
    .rd_slot_i(rd_slot_i), .conv_done_i(conv_done_i),
    .conv_result_i(conv_result_i), .parasite_i(parasite_i),
    .rd_bit_o(rd_bit_o), .rd_valid_o(rd_valid_o),
    .conv_start_o(conv_start_o), .alarm_o(alarm_o), .busy_o(busy_o),
    .rom_code_o(rom_code_o));
`default_nettype wire

// ---- bench/tsa_sensor_model.sv ----
// Sensor model that answers conversion starts after a fixed latency
`timescale 1ns/100ps
`default_nettype none
module tsa_sensor_model
    import tsa_pkg::*;
#(
    parameter int LAT = 10
) (
    input  wire logic                 mclk_i,
    input  wire logic                 rst_b_i,
    input  wire logic                 start_i,
    input  wire tsa_pkg::tsa_result_t value_i,
    output var logic                  done_o,
    output var tsa_pkg::tsa_result_t  result_o
);
    // --------
    // Sensor
    // --------
    int cnt;
    // Inverted data outside the pulse, so a late sample never matches
    assign result_o = done_o ? value_i : ~value_i;
    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt <= 0;
            done_o <= 1'b0;
        end else begin
            done_o <= (cnt == 1);
            cnt <= start_i ? LAT : (cnt > 0 ? cnt - 1 : 0);
        end
    end
endmodule
`default_nettype wire

// ---- logic/tsa_crc8.sv ----
// Byte-stream check code generator, least significant bit first
`timescale 1ns/100ps
`default_nettype none
module tsa_crc8 #(
    parameter int NBYTES = 8
) (
    input  wire logic [NBYTES*8-1:0] data_i,
    output logic      [7:0]          crc_o
);
    import tsa_pkg::*;

    // Reflected form of x^8+x^5+x^4+1, shift register starts at zero
    always_comb begin
        logic [7:0] acc;
        logic       fb;
        acc = 8'h00;
        fb  = 1'b0;
        for (int i = 0; i < NBYTES * 8; i++) begin
            fb  = acc[0] ^ data_i[i];
            acc = {1'b0, acc[7:1]};
            if (fb) begin
                acc = acc ^ CRC_POLY_REF;
            end
        end
        crc_o = acc;
    end

endmodule
`default_nettype wire

// ---- logic/tsa_pkg.sv ----
// Constants and types shared by the thermometer scratchpad logic
`default_nettype none
package tsa_pkg;

    // ------------------------------------------------------------------
    // Function command codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_CONVERT = 8'h44;
    localparam logic [7:0] CMD_WRITE   = 8'h4e;
    localparam logic [7:0] CMD_READ    = 8'hbe;
    localparam logic [7:0] CMD_COPY    = 8'h48;
    localparam logic [7:0] CMD_RECALL  = 8'hb8;
    localparam logic [7:0] CMD_POWER   = 8'hb4;
    localparam logic [7:0] CMD_ALARM_SEARCH = 8'hec;

    // ------------------------------------------------------------------
    // Scratchpad byte offsets
    // ------------------------------------------------------------------
    localparam logic [3:0] OFS_TEMP_LOW   = 4'h0;
    localparam logic [3:0] OFS_TEMP_HIGH  = 4'h1;
    localparam logic [3:0] OFS_HIGH_THR   = 4'h2;
    localparam logic [3:0] OFS_LOW_THR    = 4'h3;
    localparam logic [3:0] OFS_RSVD_A     = 4'h4;
    localparam logic [3:0] OFS_RSVD_B     = 4'h5;
    localparam logic [3:0] OFS_RESIDUAL   = 4'h6;
    localparam logic [3:0] OFS_PER_DEGREE = 4'h7;
    localparam logic [3:0] OFS_CHECK      = 4'h8;
    localparam int         SPAD_BYTES     = 9;
    localparam logic [6:0] SPAD_LAST_BIT  = 7'h47;
    localparam logic [4:0] WR_LAST_BIT    = 5'h0f;
    localparam logic [4:0] WR_FIRST_BYTE  = 5'h07;

    // ------------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------------
    localparam logic [15:0] TEMP_RESET   = 16'h00aa;
    localparam logic [7:0]  RSVD_VALUE   = 8'hff;
    localparam logic [7:0]  NV_HIGH_INIT = 8'h7f;
    localparam logic [7:0]  NV_LOW_INIT  = 8'h80;
    localparam int          CMP_MSB      = 8;
    localparam int          CMP_LSB      = 1;
    localparam logic [7:0]  CRC_POLY_REF = 8'h8c;

    // ------------------------------------------------------------------
    // Identity code; family and serial values are arbitrary
    // ------------------------------------------------------------------
    localparam logic [7:0]  FAMILY_CODE = 8'h5a;
    localparam logic [47:0] SERIAL_NUM  = 48'h0123_4567_89ab;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ           = 200;
    localparam int NV_WRITE_TIME_MS  = 10;
    localparam int NV_WRITE_CYCLES   = NV_WRITE_TIME_MS * 1000 * CLK_MHZ;
    localparam int RECALL_CYCLES     = 16;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] temperature;
        logic [7:0]  residual_count;
        logic [7:0]  counts_per_degree;
    } tsa_result_t;

    typedef enum logic [2:0] {
        ST_INIT   = 3'b000,
        ST_IDLE   = 3'b001,
        ST_WRITE  = 3'b010,
        ST_READ   = 3'b011,
        ST_CONV   = 3'b100,
        ST_COPY   = 3'b101,
        ST_RECALL = 3'b110,
        ST_POWER  = 3'b111
    } tsa_state_t;

endpackage
`default_nettype wire

// ---- logic/tsa_scratchpad.sv ----
// Thermometer scratchpad, alarm flag, power mode and identity code
//
// Function
// [R1] Compare only temperature bits 8 to 1
// [R2] Alarm when at-or-below low, above high
// [R3] Re-evaluate alarm after every conversion
// [R4] Answer alarm search only while flagged
// [R5] Master reconverts after changing thresholds
// [R6] Master strong pullup within ten microseconds
// [R7] Master holds pullup through conversion or write
// [R8] No bus traffic while pullup enabled
// [R9] Power query: low if parasite, else released
// [R10] Master learns power mode by one slot
// [R11] Identity: family, serial, check byte
// [R12] Temperature bytes are read-only
// [R13] Reserved bytes unwritable, read all ones
// [R14] Byte eight holds check over bytes 0-7
// [R15] Write command loads bytes two, three
// [R16] Read shifts out from byte zero LSB
// [R17] Copy stores thresholds into nonvolatile storage
// [R18] Power-up loads thresholds from storage
// [R19] Recall reloads; slots read 0 busy, 1 done
// [R20] Thresholds are signed bytes
// [R21] Temperature is 16-bit signed, half-degree LSB
// [R22] Conversion starts only on convert command
// [R23] Alarm clear from reset to first conversion
// [R24] Check byte recomputed whenever contents change
`timescale 1ns/100ps
`default_nettype none
module tsa_scratchpad
    import tsa_pkg::*;
#(
    parameter int          NV_WRITE_CYC = tsa_pkg::NV_WRITE_CYCLES,
    parameter int          RECALL_CYC   = tsa_pkg::RECALL_CYCLES,
    parameter logic [7:0]  FAMILY       = tsa_pkg::FAMILY_CODE,
    parameter logic [47:0] SERIAL       = tsa_pkg::SERIAL_NUM
) (
    input  wire logic                 mclk_i,
    input  wire logic                 rst_b_i,
    input  wire logic                 bus_reset_i,
    input  wire logic                 cmd_valid_i,
    input  wire logic [7:0]           cmd_code_i,
    input  wire logic                 wr_bit_valid_i,
    input  wire logic                 wr_bit_i,
    input  wire logic                 rd_slot_i,
    input  wire logic                 conv_done_i,
    input  wire tsa_pkg::tsa_result_t conv_result_i,
    input  wire logic                 parasite_i,
    output logic                      rd_bit_o,
    output logic                      rd_valid_o,
    output logic                      conv_start_o,
    output logic                      alarm_o,
    output logic                      busy_o,
    output logic [63:0]               rom_code_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    tsa_state_t  state_reg;
    tsa_state_t  state_next;
    logic [15:0] temp_reg;
    logic [7:0]  residual_reg;
    logic [7:0]  per_degree_reg;
    logic [7:0]  high_thr_reg;
    logic [7:0]  low_thr_reg;
    logic [7:0]  nv_high_reg;
    logic [7:0]  nv_low_reg;
    logic [7:0]  check_reg;
    logic        alarm_reg;
    logic [31:0] cnt_reg;
    logic [6:0]  rd_idx_reg;
    logic [4:0]  wr_idx_reg;
    logic [7:0]  wr_sh_reg;
    logic [63:0] spad_low8;
    logic [7:0]  spad_crc;
    logic [7:0]  rom_crc;
    logic        cmd_ok;
    logic        cnt_zero;
    logic        rd_bit_next;
    logic [7:0]  rd_byte;
    logic [7:0]  cmp_temp;

    localparam logic [31:0] NV_LOAD  = 32'(NV_WRITE_CYC - 1);
    localparam logic [31:0] RCL_LOAD = 32'(RECALL_CYC - 1);

    // Scratchpad byte view; reserved bytes are constant ones
    function automatic logic [7:0] spad_byte(input logic [3:0] idx,
                                             input logic [7:0] crc);
        logic [7:0] b;
        b = RSVD_VALUE;
        unique case (idx)
            OFS_TEMP_LOW:   b = temp_reg[7:0];
            OFS_TEMP_HIGH:  b = temp_reg[15:8];
            OFS_HIGH_THR:   b = high_thr_reg;
            OFS_LOW_THR:    b = low_thr_reg;
            OFS_RSVD_A:     b = RSVD_VALUE;      // [R13]
            OFS_RSVD_B:     b = RSVD_VALUE;      // [R13]
            OFS_RESIDUAL:   b = residual_reg;
            OFS_PER_DEGREE: b = per_degree_reg;
            OFS_CHECK:      b = crc;
            default:        b = RSVD_VALUE;
        endcase
        return b;
    endfunction

    // ------------------------------------------------------------------
    // Check codes
    // ------------------------------------------------------------------
    always_comb begin
        spad_low8 = '0;
        for (int i = 0; i < 8; i++) begin
            spad_low8[i*8 +: 8] = spad_byte(4'(i), 8'h00);
        end
    end

    tsa_crc8 #(
        .NBYTES (8)
    ) u_spad_crc (
        .data_i (spad_low8),
        .crc_o  (spad_crc)
    );

    tsa_crc8 #(
        .NBYTES (7)
    ) u_rom_crc (
        .data_i ({SERIAL, FAMILY}),
        .crc_o  (rom_crc)
    );

    // Registered every cycle so a read never sees a stale code
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            check_reg <= 8'h00;
        end else begin
            check_reg <= spad_crc;                                // [R14] [R24]
        end
    end

    // Loaded after reset release; reset itself only takes a constant
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rom_code_o <= 64'h0;
        end else begin
            rom_code_o <= {rom_crc, SERIAL, FAMILY};              // [R11]
        end
    end

    // ------------------------------------------------------------------
    // Command sequencing
    // ------------------------------------------------------------------
    // Busy states keep the bus to themselves, so commands are ignored
    assign cmd_ok   = cmd_valid_i && (state_reg == ST_IDLE ||
                      state_reg == ST_READ || state_reg == ST_WRITE ||
                      state_reg == ST_POWER);
    assign cnt_zero = (cnt_reg == 32'h0);

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_INIT, ST_RECALL: begin
                if (cnt_zero) begin
                    state_next = ST_IDLE;
                end
            end
            ST_COPY: begin
                if (cnt_zero) begin
                    state_next = ST_IDLE;
                end
            end
            ST_CONV: begin
                if (conv_done_i) begin
                    state_next = ST_IDLE;                         // [R22]
                end
            end
            ST_IDLE, ST_READ, ST_WRITE, ST_POWER: begin
                if (bus_reset_i) begin
                    state_next = ST_IDLE;
                end
                if (cmd_ok) begin
                    if (cmd_code_i == CMD_CONVERT) begin
                        state_next = ST_CONV;                     // [R22]
                    end else if (cmd_code_i == CMD_WRITE) begin
                        state_next = ST_WRITE;
                    end else if (cmd_code_i == CMD_READ) begin
                        state_next = ST_READ;
                    end else if (cmd_code_i == CMD_COPY) begin
                        state_next = ST_COPY;
                    end else if (cmd_code_i == CMD_RECALL) begin
                        state_next = ST_RECALL;
                    end else if (cmd_code_i == CMD_POWER) begin
                        state_next = ST_POWER;
                    end else begin
                        state_next = ST_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg <= ST_INIT;
        end else begin
            state_reg <= state_next;
        end
    end

    // Wait counter for nonvolatile write and reload
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_reg <= RCL_LOAD;
        end else if (state_reg != ST_COPY && state_next == ST_COPY) begin
            cnt_reg <= NV_LOAD;
        end else if (state_reg != ST_RECALL && state_next == ST_RECALL) begin
            cnt_reg <= RCL_LOAD;
        end else if (!cnt_zero) begin
            cnt_reg <= cnt_reg - 32'h1;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            conv_start_o <= 1'b0;
            busy_o       <= 1'b1;
        end else begin
            conv_start_o <= cmd_ok && cmd_code_i == CMD_CONVERT;  // [R22]
            busy_o       <= state_next == ST_INIT ||
                            state_next == ST_CONV ||
                            state_next == ST_COPY ||
                            state_next == ST_RECALL;
        end
    end

    // ------------------------------------------------------------------
    // Temperature and alarm
    // ------------------------------------------------------------------
    assign cmp_temp = temp_next_cmp(conv_result_i.temperature);

    function automatic logic [7:0] temp_next_cmp(input logic [15:0] t);
        return t[CMP_MSB:CMP_LSB];                                // [R1]
    endfunction

    // Temperature bytes change only through a conversion result
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            temp_reg       <= TEMP_RESET;
            residual_reg   <= 8'h00;
            per_degree_reg <= 8'h00;
        end else if (state_reg == ST_CONV && conv_done_i) begin
            temp_reg       <= conv_result_i.temperature;          // [R12] [R21]
            residual_reg   <= conv_result_i.residual_count;
            per_degree_reg <= conv_result_i.counts_per_degree;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            alarm_reg <= 1'b0;                                    // [R23]
        end else if (state_reg == ST_CONV && conv_done_i) begin
            alarm_reg <= ($signed(cmp_temp) <= $signed(low_thr_reg)) ||
                         ($signed(cmp_temp) > $signed(high_thr_reg));
                                                        // [R2] [R3] [R20]
        end
    end

    // Search logic outside joins the alarm search only on this level
    assign alarm_o = alarm_reg;                                   // [R4]

    // ------------------------------------------------------------------
    // Thresholds and nonvolatile copies
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            high_thr_reg <= 8'h00;
            low_thr_reg  <= 8'h00;
        end else if ((state_reg == ST_INIT || state_reg == ST_RECALL) &&
                     cnt_zero) begin
            high_thr_reg <= nv_high_reg;                          // [R18] [R19]
            low_thr_reg  <= nv_low_reg;
        end else if (state_reg == ST_WRITE && wr_bit_valid_i) begin
            if (wr_idx_reg == WR_FIRST_BYTE) begin
                high_thr_reg <= {wr_bit_i, wr_sh_reg[7:1]};       // [R15]
            end else if (wr_idx_reg == WR_LAST_BIT) begin
                low_thr_reg  <= {wr_bit_i, wr_sh_reg[7:1]};       // [R15]
            end
        end
    end

    // Models storage kept over power-down; bus resets keep the values, device reset loads the initial ones
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            nv_high_reg <= NV_HIGH_INIT;
            nv_low_reg  <= NV_LOW_INIT;
        end else if (state_reg == ST_COPY && cnt_zero) begin
            nv_high_reg <= high_thr_reg;                          // [R17]
            nv_low_reg  <= low_thr_reg;
        end
    end

    // Write bits arrive least significant first; extra bits are dropped
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_idx_reg <= 5'h00;
            wr_sh_reg  <= 8'h00;
        end else if (state_reg != ST_WRITE) begin
            wr_idx_reg <= 5'h00;
            wr_sh_reg  <= 8'h00;
        end else if (wr_bit_valid_i && wr_idx_reg <= WR_LAST_BIT) begin
            wr_idx_reg <= wr_idx_reg + 5'h01;
            wr_sh_reg  <= {wr_bit_i, wr_sh_reg[7:1]};             // [R15]
        end
    end

    // ------------------------------------------------------------------
    // Read slots
    // ------------------------------------------------------------------
    always_comb begin
        rd_bit_next = 1'b1;
        rd_byte     = RSVD_VALUE;
        unique case (state_reg)
            ST_READ: begin
                if (rd_idx_reg <= SPAD_LAST_BIT) begin
                    rd_byte     = spad_byte(rd_idx_reg[6:3], check_reg);
                    rd_bit_next = rd_byte[rd_idx_reg[2:0]];       // [R16]
                end
            end
            ST_POWER: begin
                rd_bit_next = !parasite_i;                        // [R9]
            end
            ST_INIT, ST_RECALL, ST_CONV, ST_COPY: begin
                rd_bit_next = 1'b0;                               // [R19]
            end
            ST_IDLE, ST_WRITE: begin
                rd_bit_next = 1'b1;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_idx_reg <= 7'h00;
        end else if (state_reg != ST_READ) begin
            rd_idx_reg <= 7'h00;
        end else if (rd_slot_i && rd_idx_reg <= SPAD_LAST_BIT) begin
            rd_idx_reg <= rd_idx_reg + 7'h01;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_bit_o   <= 1'b1;
            rd_valid_o <= 1'b0;
        end else begin
            rd_valid_o <= rd_slot_i;
            if (rd_slot_i) begin
                rd_bit_o <= rd_bit_next;
            end
        end
    end

endmodule
`default_nettype wire
